// ### lpm_pkg.sv
// Shared types and constants for the low-power mode controller
package lpm_pkg;

  // Power modes of the device
  typedef enum logic [2:0] {
    LPM_RUN,
    LPM_WAIT,
    LPM_LP_RUN,
    LPM_LP_WAIT,
    LPM_ACT_HALT,
    LPM_HALT,
    LPM_REF_WAIT
  } lpm_mode_t;

  // CPU mode requests, one-cycle pulses
  typedef struct packed {
    logic wait_for_event;
    logic wait_for_interrupt;
    logic lp_run_enter;
    logic lp_run_exit;
    logic act_halt;
    logic halt;
  } lpm_req_t;

  // Wake sources, already on the system clock
  typedef struct packed {
    logic int_irq;
    logic ext_irq;
    logic rtc_irq;
    logic periph_event;
    logic halt_wake;
  } lpm_wake_t;

  // Gating and power controls
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic rtc_clk_en;
    logic mem_nvm_en;
    logic low_speed_clk_sel;
    logic low_power_regulator_mode;
    logic ulp_regulator;
    logic ref_on;
  } lpm_ctrl_t;

  // Fast wakeup time and internal reference restart time
  localparam int LPM_FAST_WAKE_NS = 5000;
  localparam int LPM_REF_START_NS = 5000;
  localparam int LPM_CLK_NS = 10;
  localparam int LPM_FAST_WAKE_CYC = LPM_FAST_WAKE_NS / LPM_CLK_NS;
  localparam int LPM_REF_START_CYC = LPM_REF_START_NS / LPM_CLK_NS;
  localparam int LPM_CNT_W = 12;

  // Reset values of the controls
  localparam lpm_ctrl_t LPM_CTRL_RST = 8'hd1;

endpackage

// ### lpm_wake_sync.sv
// Three-stage synchroniser for a pin-level wake input
`timescale 1ns/100ps
`default_nettype none
module lpm_wake_sync (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic pin_in,
  output logic level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;
  logic lvl_nxt;

  // Level changes only once stages two and three agree
  always_comb
  begin
    lvl_nxt = lvl_r;
    if (s2_r == s3_r)
    begin
      lvl_nxt = s3_r;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      lvl_r <= 1'b0;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_out = lvl_r;
endmodule
`default_nettype wire

// ### lpm_wake_timer.sv
// Down-counter that times the wakeup delay
`timescale 1ns/100ps
`default_nettype none
module lpm_wake_timer #(
  parameter int CNT_W = 12
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic load_in,
  input wire logic [CNT_W-1:0] count_in,
  output logic done_out
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  // Load wins over counting
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (load_in)
    begin
      cnt_nxt = count_in;
    end
    else if (cnt_r != '0)
    begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done_out = (cnt_r == '0) && !load_in;
endmodule
`default_nettype wire

// ### lpm_ctrl.sv
// Low-power mode controller: mode state machine and clock/power gating
`timescale 1ns/100ps
`default_nettype none
// How it works
// R1: Wait stops CPU clock, peripherals keep running
// R2: Wait exits on internal or external interrupt
// R3: Wait entered by event or interrupt instruction
// R4: Low-power run uses low-speed clock, RAM code
// R5: Low-power run stops flash, regulator ultra-low
// R6: Low-power run entered and left by software
// R7: Interrupts never exit low-power run or wait
// R8: Event instruction in low-power run enters wait
// R9: Low-power wait wakes on peripheral event
// R10: Event wake returns to low-power run
// R11: Active-halt keeps only the RTC clock
// R12: Active-halt wakes on RTC or external interrupt
// R13: Halt stops all clocks, RAM kept
// R14: Halt wakes on external or peripheral wake
// R15: Reference off in halt, optional fast wake
// R16: Halt modes switch regulator to low-power
// R17: Reset ends any mode into run
module lpm_ctrl (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire lpm_pkg::lpm_req_t req_in,
  input wire lpm_pkg::lpm_wake_t wake_in,
  input wire logic ext_irq_pin_in,
  input wire logic ref_off_halt_in,
  input wire logic fast_wake_in,
  input wire logic low_speed_ext_in,
  output lpm_pkg::lpm_ctrl_t ctrl_out,
  output lpm_pkg::lpm_mode_t mode_out,
  output logic wake_event_out,
  output logic wake_was_event_out
);
  lpm_pkg::lpm_mode_t mode_r;
  lpm_pkg::lpm_mode_t mode_nxt;
  lpm_pkg::lpm_ctrl_t ctrl_r;
  lpm_pkg::lpm_ctrl_t ctrl_nxt;
  logic wfe_r;
  logic wfe_nxt;
  logic ref_off_r;
  logic ref_off_nxt;
  logic wake_r;
  logic wake_nxt;
  logic evt_r;
  logic evt_nxt;
  logic ext_pin_lvl;
  logic ext_any;
  logic tmr_load;
  logic tmr_done;
  logic [lpm_pkg::LPM_CNT_W-1:0] tmr_count;

  // External interrupt pin comes from outside the clock domain
  lpm_wake_sync u_ext_sync (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .pin_in(ext_irq_pin_in),
    .level_out(ext_pin_lvl)
  );

  // Times the reference restart, or the fast wakeup if selected or if the reference stayed on
  lpm_wake_timer #(
    .CNT_W(lpm_pkg::LPM_CNT_W)
  ) u_wake_tmr (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .load_in(tmr_load),
    .count_in(tmr_count),
    .done_out(tmr_done)
  );

  assign ext_any = wake_in.ext_irq | ext_pin_lvl;

  // Controls implied by a mode
  function automatic lpm_pkg::lpm_ctrl_t ctrl_of(input lpm_pkg::lpm_mode_t m,
                                                 input logic ref_off,
                                                 input logic low_speed_external_osc);
    lpm_pkg::lpm_ctrl_t c;
    c = lpm_pkg::LPM_CTRL_RST;
    unique case (m)
      lpm_pkg::LPM_RUN:
      begin
        c = lpm_pkg::LPM_CTRL_RST;
      end
      lpm_pkg::LPM_WAIT:
      begin
        c.cpu_clk_en = 1'b0; // R1
      end
      lpm_pkg::LPM_LP_RUN, lpm_pkg::LPM_LP_WAIT:
      begin
        c.cpu_clk_en = (m == lpm_pkg::LPM_LP_RUN); // R8
        c.mem_nvm_en = 1'b0; // R5
        c.low_speed_clk_sel = 1'b1; // R4
        c.ulp_regulator = 1'b1; // R5
        c.low_power_regulator_mode = 1'b1;
      end
      lpm_pkg::LPM_ACT_HALT:
      begin
        c.cpu_clk_en = 1'b0; // R11
        c.periph_clk_en = 1'b0; // R11
        c.rtc_clk_en = 1'b1; // R11
        c.low_power_regulator_mode = 1'b1; // R16
      end
      lpm_pkg::LPM_HALT, lpm_pkg::LPM_REF_WAIT:
      begin
        c.cpu_clk_en = 1'b0; // R13
        c.periph_clk_en = 1'b0; // R13
        c.rtc_clk_en = 1'b0;
        c.low_power_regulator_mode = 1'b1; // R16
        c.ref_on = !(ref_off && m == lpm_pkg::LPM_HALT); // R15
      end
    endcase
    c.low_speed_clk_sel = c.low_speed_clk_sel & 1'b1;
    if (m == lpm_pkg::LPM_LP_RUN || m == lpm_pkg::LPM_LP_WAIT)
    begin
      c.ulp_regulator = !low_speed_external_osc | 1'b1;
    end
    return c;
  endfunction

  // Mode sequencing; reset takes every mode back to run
  always_comb
  begin
    mode_nxt = mode_r;
    wfe_nxt = wfe_r;
    ref_off_nxt = ref_off_r;
    wake_nxt = 1'b0;
    evt_nxt = 1'b0;
    tmr_load = 1'b0;
    tmr_count = lpm_pkg::LPM_CNT_W'(lpm_pkg::LPM_REF_START_CYC);
    unique case (mode_r)
      lpm_pkg::LPM_RUN:
      begin
        if (req_in.wait_for_event || req_in.wait_for_interrupt)
        begin
          mode_nxt = lpm_pkg::LPM_WAIT; // R3
          wfe_nxt = req_in.wait_for_event; // R3
        end
        else if (req_in.lp_run_enter)
        begin
          mode_nxt = lpm_pkg::LPM_LP_RUN; // R6
        end
        else if (req_in.act_halt)
        begin
          mode_nxt = lpm_pkg::LPM_ACT_HALT; // R16
        end
        else if (req_in.halt)
        begin
          mode_nxt = lpm_pkg::LPM_HALT; // R16
          ref_off_nxt = ref_off_halt_in; // R15
        end
      end
      lpm_pkg::LPM_WAIT:
      begin
        // Event variant also wakes on peripheral events
        if (wake_in.int_irq || ext_any || (wfe_r && wake_in.periph_event))
        begin
          mode_nxt = lpm_pkg::LPM_RUN; // R2
          wake_nxt = 1'b1;
          evt_nxt = wfe_r && !wake_in.int_irq && !ext_any;
        end
      end
      lpm_pkg::LPM_LP_RUN:
      begin
        // Interrupts are deliberately ignored here
        if (req_in.lp_run_exit)
        begin
          mode_nxt = lpm_pkg::LPM_RUN; // R6
        end
        else if (req_in.wait_for_event)
        begin
          mode_nxt = lpm_pkg::LPM_LP_WAIT; // R8
        end
      end
      lpm_pkg::LPM_LP_WAIT:
      begin
        // Only events wake; interrupts are not exit sources
        if (wake_in.periph_event) // R7
        begin
          mode_nxt = lpm_pkg::LPM_LP_RUN; // R10
          wake_nxt = 1'b1; // R9
          evt_nxt = 1'b1; // R9
        end
      end
      lpm_pkg::LPM_ACT_HALT:
      begin
        if (wake_in.rtc_irq || ext_any)
        begin
          mode_nxt = lpm_pkg::LPM_RUN; // R12
          wake_nxt = 1'b1;
        end
      end
      lpm_pkg::LPM_HALT:
      begin
        if (ext_any || wake_in.halt_wake)
        begin
          // With the reference off and no fast wake, wait for the reference to restart
          tmr_load = 1'b1; // R14
          if (ref_off_r && !fast_wake_in)
          begin
            tmr_count = lpm_pkg::LPM_CNT_W'(lpm_pkg::LPM_REF_START_CYC);
          end
          else
          begin
            tmr_count = lpm_pkg::LPM_CNT_W'(lpm_pkg::LPM_FAST_WAKE_CYC); // R15
          end
          mode_nxt = lpm_pkg::LPM_REF_WAIT;
        end
      end
      lpm_pkg::LPM_REF_WAIT:
      begin
        if (tmr_done)
        begin
          mode_nxt = lpm_pkg::LPM_RUN;
          wake_nxt = 1'b1;
        end
      end
      default:
      begin
        mode_nxt = lpm_pkg::LPM_RUN;
      end
    endcase
    ctrl_nxt = ctrl_of(mode_nxt, ref_off_nxt, low_speed_ext_in);
  end

  // State registers; async reset gives normal run
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      mode_r <= lpm_pkg::LPM_RUN; // R17
      ctrl_r <= lpm_pkg::LPM_CTRL_RST; // R17
      wfe_r <= 1'b0;
      ref_off_r <= 1'b0;
      wake_r <= 1'b0;
      evt_r <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      ctrl_r <= ctrl_nxt;
      wfe_r <= wfe_nxt;
      ref_off_r <= ref_off_nxt;
      wake_r <= wake_nxt;
      evt_r <= evt_nxt;
    end
  end

  assign ctrl_out = ctrl_r;
  assign mode_out = mode_r;
  assign wake_event_out = wake_r;
  assign wake_was_event_out = evt_r;

  // Checks
  sequence s_lpw_evt;
    mode_r == lpm_pkg::LPM_LP_WAIT && wake_in.periph_event;
  endsequence

  sequence s_halt_wake;
    mode_r == lpm_pkg::LPM_HALT && (ext_any || wake_in.halt_wake);
  endsequence

  a_wait_cpu_off: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R1
    mode_r == lpm_pkg::LPM_WAIT |-> !ctrl_out.cpu_clk_en && ctrl_out.periph_clk_en)
    else $error("cpu clock running in wait");
  a_wait_irq_exit: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R2
    mode_r == lpm_pkg::LPM_WAIT && wake_in.int_irq |=> mode_r == lpm_pkg::LPM_RUN && wake_r)
    else $error("wait not left on interrupt");
  a_wait_entry: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R3
    mode_r == lpm_pkg::LPM_RUN && req_in.wait_for_interrupt |=> mode_r == lpm_pkg::LPM_WAIT)
    else $error("wait not entered");
  a_lprun_ctrl: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R5
    mode_r == lpm_pkg::LPM_LP_RUN |-> !ctrl_out.mem_nvm_en && ctrl_out.ulp_regulator
      && ctrl_out.low_speed_clk_sel && ctrl_out.cpu_clk_en)
    else $error("low-power run controls wrong");
  a_lp_no_irq: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R7
    mode_r == lpm_pkg::LPM_LP_WAIT && !wake_in.periph_event |=> mode_r == lpm_pkg::LPM_LP_WAIT)
    else $error("low-power wait left without event");
  a_lpw_return: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R10
    s_lpw_evt |=> mode_r == lpm_pkg::LPM_LP_RUN && wake_r && evt_r)
    else $error("event wake did not return to low-power run");
  a_ahalt_rtc: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R11
    mode_r == lpm_pkg::LPM_ACT_HALT |-> ctrl_out.rtc_clk_en && !ctrl_out.periph_clk_en
      && ctrl_out.low_power_regulator_mode)
    else $error("active-halt gating wrong");
  a_halt_fast: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R15
    s_halt_wake ##1 (mode_r == lpm_pkg::LPM_REF_WAIT && fast_wake_in)
      |-> ##[1:600] mode_r == lpm_pkg::LPM_RUN)
    else $error("halt wake too slow");
  a_lpwait_ctrl: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R8
    mode_r == lpm_pkg::LPM_LP_WAIT |-> !ctrl_out.cpu_clk_en && !ctrl_out.mem_nvm_en)
    else $error("low-power wait controls wrong");
  a_ahalt_wake: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R12
    mode_r == lpm_pkg::LPM_ACT_HALT && wake_in.rtc_irq |=> mode_r == lpm_pkg::LPM_RUN && wake_r)
    else $error("active-halt not left on rtc interrupt");
  a_halt_stop: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R13
    mode_r == lpm_pkg::LPM_HALT |-> !ctrl_out.cpu_clk_en && !ctrl_out.periph_clk_en)
    else $error("halt gating wrong");
  a_halt_hold: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // R14
    mode_r == lpm_pkg::LPM_HALT && !ext_any && !wake_in.halt_wake
      |=> mode_r == lpm_pkg::LPM_HALT)
    else $error("halt left without wake source");
endmodule
`default_nettype wire

// ### lpm_far_model.sv
// Far-side model: wake sources and interrupt pin held until serviced
`timescale 1ns/100ps
`default_nettype none
module lpm_far_model (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire lpm_pkg::lpm_wake_t raise_in,
  input wire logic pin_raise_in,
  input wire logic drop_in,
  input wire logic wake_ack_in,
  output lpm_pkg::lpm_wake_t wake_out,
  output logic pin_out
);
  lpm_pkg::lpm_wake_t wake_r;
  lpm_pkg::lpm_wake_t wake_nxt;
  logic pin_r;
  logic pin_nxt;
  // Requests stay up until the device wakes, or software masks them
  always_comb
  begin
    wake_nxt = wake_r | raise_in;
    pin_nxt = pin_r | pin_raise_in;
    if (wake_ack_in || drop_in)
    begin
      wake_nxt = '0;
      pin_nxt = 1'b0;
    end
  end
  // Idle level low, so a released pin never keeps a stale request
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      wake_r <= '0;
      pin_r <= 1'b0;
    end
    else
    begin
      wake_r <= wake_nxt;
      pin_r <= pin_nxt;
    end
  end
  assign wake_out = wake_r;
  assign pin_out = pin_r;
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the low-power mode controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  lpm_pkg::lpm_req_t req = '0;
  lpm_pkg::lpm_wake_t raise = '0;
  lpm_pkg::lpm_wake_t wake;
  lpm_pkg::lpm_ctrl_t ctrl;
  lpm_pkg::lpm_mode_t mode;
  logic pin_raise = 1'b0;
  logic drop = 1'b0;
  logic ref_off = 1'b0;
  logic fast = 1'b0;
  logic low_speed_external_osc = 1'b0;
  logic pin;
  logic wk;
  logic wk_evt;
  int failures = 0;
  int tests_run = 0;
  int n_wk = 0;
  int n_evt = 0;

  lpm_ctrl dut (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .req_in(req),
    .wake_in(wake),
    .ext_irq_pin_in(pin),
    .ref_off_halt_in(ref_off),
    .fast_wake_in(fast),
    .low_speed_ext_in(low_speed_external_osc),
    .ctrl_out(ctrl),
    .mode_out(mode),
    .wake_event_out(wk),
    .wake_was_event_out(wk_evt)
  );

  lpm_far_model far (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .raise_in(raise),
    .pin_raise_in(pin_raise),
    .drop_in(drop),
    .wake_ack_in(wk),
    .wake_out(wake),
    .pin_out(pin)
  );

  // Clock and wake pulse counters
  always #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in)
  begin
    if (wk === 1'b1) n_wk++;
    if (wk_evt === 1'b1) n_evt++;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk_mode(input lpm_pkg::lpm_mode_t exp);
    tests_run++;
    if (mode !== exp)
    begin
      failures++;
      $display("unexpected at %0t: mode %0d not %0d", $time, mode, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: flag %b not %b", $time, got, exp);
    end
  endtask

  // All drives land 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic send(input lpm_pkg::lpm_req_t r);
    req = r;
    step(1);
    req = '0;
  endtask

  task automatic fire(input lpm_pkg::lpm_wake_t w, input logic p);
    raise = w;
    pin_raise = p;
    step(1);
    raise = '0;
    pin_raise = 1'b0;
  endtask

  // Masking interrupts in software; sync residue needs a few cycles
  task automatic clear();
    drop = 1'b1;
    step(1);
    drop = 1'b0;
    step(6);
  endtask

  task automatic settle(input lpm_pkg::lpm_mode_t exp, input int lim);
    for (int i = 0; i < lim && mode !== exp; i++) step(1);
    chk_mode(exp);
  endtask

  task automatic t_wait(input lpm_pkg::lpm_req_t r, input lpm_pkg::lpm_wake_t w, input logic p,
                        input logic ev);
    int n0;
    int e0;
    n0 = n_wk;
    e0 = n_evt;
    send(r);
    chk_mode(lpm_pkg::LPM_WAIT);
    chk_bit(ctrl.cpu_clk_en, 1'b0);
    chk_bit(ctrl.periph_clk_en, 1'b1);
    fire(w, p);
    settle(lpm_pkg::LPM_RUN, 8);
    step(1);
    chk_bit(n_wk == n0 + 1, 1'b1);
    chk_bit(n_evt == e0 + ev, 1'b1);
    // Pin level lingers in the synchroniser; let it drain before the next request
    step(6);
    $display("test wait done");
  endtask

  task automatic t_lprun();
    int n0;
    n0 = n_evt;
    send(6'h08);
    chk_mode(lpm_pkg::LPM_LP_RUN);
    chk_bit(ctrl.low_speed_clk_sel, 1'b1);
    chk_bit(ctrl.cpu_clk_en, 1'b1);
    chk_bit(ctrl.mem_nvm_en, 1'b0);
    chk_bit(ctrl.ulp_regulator, 1'b1);
    fire(5'h18, 1'b1);
    step(8);
    chk_mode(lpm_pkg::LPM_LP_RUN);
    clear();
    send(6'h20);
    chk_mode(lpm_pkg::LPM_LP_WAIT);
    chk_bit(ctrl.cpu_clk_en, 1'b0);
    chk_bit(ctrl.mem_nvm_en, 1'b0);
    fire(5'h18, 1'b1);
    step(8);
    chk_mode(lpm_pkg::LPM_LP_WAIT);
    clear();
    fire(5'h02, 1'b0);
    settle(lpm_pkg::LPM_LP_RUN, 4);
    step(1);
    chk_bit(n_evt == n0 + 1, 1'b1);
    send(6'h04);
    chk_mode(lpm_pkg::LPM_RUN);
    chk_bit(ctrl.mem_nvm_en, 1'b1);
    $display("test low-power run done");
  endtask

  task automatic t_ahalt();
    send(6'h02);
    chk_mode(lpm_pkg::LPM_ACT_HALT);
    chk_bit(ctrl.rtc_clk_en, 1'b1);
    chk_bit(ctrl.cpu_clk_en, 1'b0);
    chk_bit(ctrl.periph_clk_en, 1'b0);
    chk_bit(ctrl.low_power_regulator_mode, 1'b1);
    fire(5'h02, 1'b0);
    step(6);
    chk_mode(lpm_pkg::LPM_ACT_HALT);
    clear();
    fire(5'h04, 1'b0);
    settle(lpm_pkg::LPM_RUN, 600);
    $display("test active-halt done");
  endtask

  task automatic t_halt(input logic ro, input logic fw, input lpm_pkg::lpm_wake_t w,
                        input int cyc);
    int n;
    ref_off = ro;
    fast = fw;
    send(6'h01);
    chk_mode(lpm_pkg::LPM_HALT);
    chk_bit(ctrl.cpu_clk_en, 1'b0);
    chk_bit(ctrl.periph_clk_en, 1'b0);
    chk_bit(ctrl.ref_on, !ro);
    chk_bit(ctrl.low_power_regulator_mode, 1'b1);
    fire(5'h10, 1'b0);
    step(4);
    chk_mode(lpm_pkg::LPM_HALT);
    clear();
    fire(w, 1'b0);
    settle(lpm_pkg::LPM_REF_WAIT, 4);
    n = 0;
    while (mode === lpm_pkg::LPM_REF_WAIT && n < 2000)
    begin
      n++;
      step(1);
    end
    chk_mode(lpm_pkg::LPM_RUN);
    chk_bit(n >= cyc - 4 && n <= cyc + 4, 1'b1);
    $display("test halt done");
  endtask

  task automatic t_rst();
    send(6'h08);
    send(6'h20);
    chk_mode(lpm_pkg::LPM_LP_WAIT);
    sys_rst_in = 1'b1;
    step(1);
    chk_mode(lpm_pkg::LPM_RUN);
    chk_bit(ctrl === lpm_pkg::LPM_CTRL_RST, 1'b1);
    sys_rst_in = 1'b0;
    step(1);
    $display("test reset exit done");
  endtask

  // Main sequence
  initial
  begin
    step(16);
    sys_rst_in = 1'b0;
    chk_mode(lpm_pkg::LPM_RUN);
    chk_bit(ctrl === lpm_pkg::LPM_CTRL_RST, 1'b1);
    t_wait(6'h10, 5'h10, 1'b0, 1'b0);
    t_wait(6'h20, 5'h00, 1'b1, 1'b0);
    t_wait(6'h10, 5'h08, 1'b0, 1'b0);
    t_wait(6'h20, 5'h02, 1'b0, 1'b1);
    t_lprun();
    t_ahalt();
    t_halt(1'b1, 1'b1, 5'h08, lpm_pkg::LPM_FAST_WAKE_CYC);
    t_halt(1'b0, 1'b0, 5'h01, lpm_pkg::LPM_FAST_WAKE_CYC);
    t_halt(1'b1, 1'b0, 5'h08, lpm_pkg::LPM_REF_START_CYC);
    t_rst();
    end_of_test();
  end

  // Watchdog, well past the fewer than two thousand cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
